// *** hdl/tap_port_front.sv ***
// test access port front end sampled by the core clock
`timescale 1ns/100ps
`include "tap_port_cfg.svh"

module tap_port_front
    import tap_port_pkg::*;
#(
    // identity value is arbitrary; bit 0 kept high as a presence mark
    parameter logic [31:0] ID_CODE = 32'h0000_0001
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire pins_t            pin_lvl,
    input  wire pins_t            pin_drv,
    output logic                  tdo,
    output logic                  tdo_oe,
    output logic                  test_reset,
    output logic [`IR_W-1:0]      instr
);

    // pin resolution: an undriven pin reads as the pull-up level
    pins_t                 pin_res;
    pins_t                 sync1_r;
    pins_t                 sync2_r;
    logic                  tck_prev_r;
    logic                  rise;
    logic                  fall;

    tap_state_t            state_r;
    tap_state_t            state_nxt;
    logic [`IR_W-1:0]      ir_r;
    logic [`IR_W-1:0]      ir_nxt;
    logic [`IR_W-1:0]      ir_sh_r;
    logic [`IR_W-1:0]      ir_sh_nxt;
    logic [`DR_W-1:0]      id_sh_r;
    logic [`DR_W-1:0]      id_sh_nxt;
    logic                  byp_r;
    logic                  byp_nxt;
    logic                  tdo_r;
    logic                  tdo_nxt;
    logic                  tdo_oe_r;
    logic                  tdo_oe_nxt;
    logic                  shifting;
    logic                  ser_out;
    logic                  sel_ident;

    always_comb begin
        pin_res.tck = pin_drv.tck ? pin_lvl.tck : 1'b1;
        pin_res.tms = pin_drv.tms ? pin_lvl.tms : 1'b1;
        pin_res.tdi = pin_drv.tdi ? pin_lvl.tdi : 1'b1;
    end

    // two stages for every pin; the test clock is slow against mclk,
    // so mode select and data keep their alignment to the clock edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r    <= `SYNC_RESET;
            sync2_r    <= `SYNC_RESET;
            tck_prev_r <= 1'b1;
        end else begin
            sync1_r    <= pin_res;
            sync2_r    <= sync1_r;
            tck_prev_r <= sync2_r.tck;
        end
    end

    assign rise = sync2_r.tck & ~tck_prev_r;
    assign fall = ~sync2_r.tck & tck_prev_r;

    // controller transitions depend on sampled mode select only
    always_comb begin
        state_nxt = state_r;
        if (rise) begin
            case (state_r)
                ST_TLR:  state_nxt = sync2_r.tms ? ST_TLR  : ST_RTI;
                ST_RTI:  state_nxt = sync2_r.tms ? ST_SDRS : ST_RTI;
                ST_SDRS: state_nxt = sync2_r.tms ? ST_SIRS : ST_CDR;
                ST_CDR:  state_nxt = sync2_r.tms ? ST_E1DR : ST_SHDR;
                ST_SHDR: state_nxt = sync2_r.tms ? ST_E1DR : ST_SHDR;
                ST_E1DR: state_nxt = sync2_r.tms ? ST_UDR  : ST_PDR;
                ST_PDR:  state_nxt = sync2_r.tms ? ST_E2DR : ST_PDR;
                ST_E2DR: state_nxt = sync2_r.tms ? ST_UDR  : ST_SHDR;
                ST_UDR:  state_nxt = sync2_r.tms ? ST_SDRS : ST_RTI;
                ST_SIRS: state_nxt = sync2_r.tms ? ST_TLR  : ST_CIR;
                ST_CIR:  state_nxt = sync2_r.tms ? ST_E1IR : ST_SHIR;
                ST_SHIR: state_nxt = sync2_r.tms ? ST_E1IR : ST_SHIR;
                ST_E1IR: state_nxt = sync2_r.tms ? ST_UIR  : ST_PIR;
                ST_PIR:  state_nxt = sync2_r.tms ? ST_E2IR : ST_PIR;
                ST_E2IR: state_nxt = sync2_r.tms ? ST_UIR  : ST_SHIR;
                ST_UIR:  state_nxt = sync2_r.tms ? ST_SDRS : ST_RTI;
                default: state_nxt = ST_TLR;
            endcase
        end
    end

    // anything other than the identify code routes through bypass
    assign sel_ident = (ir_r == `INS_IDENT);
    assign shifting  = (state_r == ST_SHIR) || (state_r == ST_SHDR);

    always_comb begin
        if (state_r == ST_SHIR) begin
            ser_out = ir_sh_r[0];
        end else if (sel_ident) begin
            ser_out = id_sh_r[0];
        end else begin
            ser_out = byp_r;
        end
    end

    // instruction and data register next values
    always_comb begin
        ir_nxt    = ir_r;
        ir_sh_nxt = ir_sh_r;
        id_sh_nxt = id_sh_r;
        byp_nxt   = byp_r;
        if (rise) begin
            case (state_r)
                ST_TLR: begin
                    ir_nxt = `INS_IDENT;
                end
                ST_CIR: begin
                    ir_sh_nxt = {`IR_CAP_TOP, `IR_CAP_PAT};
                end
                ST_SHIR: begin
                    ir_sh_nxt = {sync2_r.tdi, ir_sh_r[`IR_W-1:1]};
                end
                ST_UIR: begin
                    ir_nxt = ir_sh_r;
                end
                ST_CDR: begin
                    if (sel_ident) begin
                        id_sh_nxt = ID_CODE;
                    end else begin
                        byp_nxt = 1'b0;
                    end
                end
                ST_SHDR: begin
                    if (sel_ident) begin
                        id_sh_nxt = {sync2_r.tdi, id_sh_r[`DR_W-1:1]};
                    end else begin
                        byp_nxt = sync2_r.tdi;
                    end
                end
                default: begin
                    ir_nxt = ir_r;
                end
            endcase
            // entry into reset presets the instruction at once
            if (state_nxt == ST_TLR) begin
                ir_nxt = `INS_IDENT;
            end
        end
    end

    // output only moves on the falling edge, half a test clock after shift
    always_comb begin
        tdo_nxt    = tdo_r;
        tdo_oe_nxt = tdo_oe_r;
        if (fall) begin
            tdo_oe_nxt = shifting;
            tdo_nxt    = shifting ? ser_out : 1'b0;
        end
    end

    // power-up is the only asynchronous reset; no test reset pin exists
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r  <= ST_TLR;
            ir_r     <= `INS_IDENT;
            ir_sh_r  <= '0;
            id_sh_r  <= '0;
            byp_r    <= 1'b0;
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            ir_r     <= ir_nxt;
            ir_sh_r  <= ir_sh_nxt;
            id_sh_r  <= id_sh_nxt;
            byp_r    <= byp_nxt;
            tdo_r    <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    // status outputs, registered
    logic                  test_reset_r;
    logic [`IR_W-1:0]      instr_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            test_reset_r <= 1'b1;
            instr_r      <= `INS_IDENT;
        end else begin
            test_reset_r <= (state_nxt == ST_TLR);
            instr_r      <= ir_nxt;
        end
    end

    assign tdo        = tdo_r;
    assign tdo_oe     = tdo_oe_r;
    assign test_reset = test_reset_r;
    assign instr      = instr_r;

    // helper: consecutive rising edges seen with mode select high
    logic [2:0]            tms_run_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tms_run_r <= 3'h0;
        end else if (rise) begin
            if (!sync2_r.tms) begin
                tms_run_r <= 3'h0;
            end else if (tms_run_r != `RESET_EDGES) begin
                tms_run_r <= tms_run_r + 3'h1;
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    five_ones_reset_a: assert property (
        (tms_run_r == `RESET_EDGES) |-> (state_r == ST_TLR))
        else $error("five high mode select edges did not reset");

    reset_preset_a: assert property (
        (state_r == ST_TLR) |-> (ir_r == `INS_IDENT))
        else $error("instruction not preset in reset state");

    capture_pattern_a: assert property (
        (rise && state_r == ST_CIR) |=> (ir_sh_r[1:0] == 2'h1))
        else $error("capture-ir did not load 01");

    instr_hold_a: assert property (
        !(rise && (state_r == ST_UIR || sync2_r.tms)) |=> $stable(ir_r))
        else $error("instruction changed outside update");

    tdo_fall_only_a: assert property (
        ($changed(tdo_r) || $changed(tdo_oe_r)) |-> $past(fall))
        else $error("serial output moved off a falling edge");

    tdo_enable_a: assert property (
        (fall && !shifting) |=> (!tdo_oe_r && !tdo_r))
        else $error("serial output active outside shift");

    bypass_delay_a: assert property (
        (rise && state_r == ST_SHDR && !sel_ident)
        |=> (byp_r == $past(sync2_r.tdi)))
        else $error("bypass flop did not take data input");

    idle_hold_a: assert property (
        !rise |=> $stable(state_r))
        else $error("controller moved without a clock edge");

    idle_loop_a: assert property (
        (rise && state_r == ST_RTI && !sync2_r.tms) |=> (state_r == ST_RTI))
        else $error("run-test idle did not hold on low mode select");

    // serial output pair moves together, off only outside shift states
    tdo_quiet_a: assert property (
        !tdo_oe_r |-> !tdo_r)
        else $error("serial output high while not driven");

    oe_in_shift_a: assert property (
        (fall && shifting) |=> tdo_oe_r)
        else $error("serial output not driven during shift");

    oe_from_fall_a: assert property (
        fall |=> (tdo_oe_r == $past(shifting)))
        else $error("output enable did not follow the falling edge");

    tms_high_tlr_a: assert property (
        (rise && state_r == ST_TLR && sync2_r.tms) |=> (state_r == ST_TLR))
        else $error("reset state left with mode select high");

    ir_shift_a: assert property (
        (rise && state_r == ST_SHIR)
        |=> (ir_sh_r[`IR_W-1] == $past(sync2_r.tdi)))
        else $error("instruction shifter did not take data input");

    update_load_a: assert property (
        (rise && state_r == ST_UIR) |=> (ir_r == $past(ir_sh_r)))
        else $error("update did not load the shifted instruction");

    id_capture_a: assert property (
        (rise && state_r == ST_CDR && sel_ident) |=> (id_sh_r == ID_CODE))
        else $error("identity value not captured");

    bypass_capture_a: assert property (
        (rise && state_r == ST_CDR && !sel_ident) |=> !byp_r)
        else $error("bypass flop did not capture zero");

    // status outputs are registered copies; they must never drift apart
    status_track_a: assert property (
        test_reset_r == (state_r == ST_TLR))
        else $error("reset status does not match controller state");

    instr_track_a: assert property (
        instr_r == ir_r)
        else $error("active instruction output does not match register");

endmodule

// *** hdl/tap_port_cfg.svh ***
// constants for the serial test access port front end
// Contract
// - controller and serial registers behave as standard boundary-scan port.
// - port resets at power-up and stays idle while no test clock edges.
// - undriven test clock, mode select and data input read high.
// - undriven mode select acts exactly as logic one for the controller.
// - undriven data input shifts ones into the selected register.
// - mode select and data input sampled on test clock rising edge.
// - sampled mode select alone steers each controller transition.
// - state plus loaded instruction choose the register between input and output.
// - serial output driven only while a register shifts, else inactive.
// - serial output changes only on test clock falling edge.
// - no separate test reset pin; reset only from power-up or mode select.
// - instruction register three bits, preset to identify instruction on reset.
// - capture-ir loads 01 into two low instruction bits.
// - new instruction takes effect only at update-ir.
// - bypass path is one flip-flop, one test clock of delay.
`ifndef TAP_PORT_CFG_SVH
`define TAP_PORT_CFG_SVH

`define IR_W        3
`define DR_W        32
`define INS_EXTEST  3'h0
`define INS_IDENT   3'h1
`define INS_BYPASS  3'h7
`define IR_CAP_PAT  2'h1
`define IR_CAP_TOP  1'h0
`define RESET_EDGES 3'h5
`define SYNC_RESET  3'h7

`endif

// *** hdl/tap_port_pkg.sv ***
// types for the serial test access port front end
package tap_port_pkg;

    typedef enum logic [15:0] {
        ST_TLR  = 16'h0001,
        ST_RTI  = 16'h0002,
        ST_SDRS = 16'h0004,
        ST_CDR  = 16'h0008,
        ST_SHDR = 16'h0010,
        ST_E1DR = 16'h0020,
        ST_PDR  = 16'h0040,
        ST_E2DR = 16'h0080,
        ST_UDR  = 16'h0100,
        ST_SIRS = 16'h0200,
        ST_CIR  = 16'h0400,
        ST_SHIR = 16'h0800,
        ST_E1IR = 16'h1000,
        ST_PIR  = 16'h2000,
        ST_E2IR = 16'h4000,
        ST_UIR  = 16'h8000
    } tap_state_t;

    // one bit per test pin, same order everywhere
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } pins_t;

endpackage

// *** tb/jtag_ctl_model.sv ***
// behavioural scan controller that drives the test pins
`timescale 1ns/100ps
module jtag_ctl_model
    import tap_port_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  tdo,
    input  wire logic  tdo_oe,
    output pins_t      pin_lvl,
    output pins_t      pin_drv,
    output logic       got,
    output logic [1:0] got_val
);
    initial begin
        pin_drv = 3'h0;
        pin_lvl = 3'h7;
        got     = 1'b0;
        got_val = 2'h0;
    end

    // one test clock period of 32 core cycles; clock idles high after
    task automatic step(input logic ms, di, dms, ddi);
        @(posedge mclk);
        pin_drv <= {1'b1, dms, ddi};
        pin_lvl <= {1'b0, ms | ~dms, di | ~ddi};
        repeat (15) @(posedge mclk);
        // output sampled late in the low phase, just before the rise
        got_val <= {tdo_oe, tdo};
        got     <= 1'b1;
        @(posedge mclk);
        got         <= 1'b0;
        pin_lvl.tck <= 1'b1;
        repeat (15) @(posedge mclk);
    endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the test access port front end
`timescale 1ns/100ps
module tb_top
    import tap_port_pkg::*;
;
    localparam logic [31:0] ID_VAL = 32'h5A3C_96E1; // arbitrary value
    logic       mclk  = 1'b0;
    logic       rst_b = 1'b0;
    pins_t      pin_lvl, pin_drv;
    logic       tdo, tdo_oe, test_reset, got, prev, di, dd;
    logic [1:0] got_val;
    logic [2:0] instr, code;
    logic [1:0] exp_q[$];
    int         fails = 0;
    int         cmp_count = 0;
    int         cyc = 0;

    always #2.5 mclk = ~mclk;

    tap_port_front #(.ID_CODE(ID_VAL)) i_tap_port_front (
        .mclk(mclk), .rst_b(rst_b), .pin_lvl(pin_lvl), .pin_drv(pin_drv),
        .tdo(tdo), .tdo_oe(tdo_oe), .test_reset(test_reset), .instr(instr));

    jtag_ctl_model i_jtag_ctl_model (
        .mclk(mclk), .tdo(tdo), .tdo_oe(tdo_oe), .pin_lvl(pin_lvl),
        .pin_drv(pin_drv), .got(got), .got_val(got_val));

    task automatic chk(input logic [3:0] a, input logic [3:0] b);
        cmp_count++;
        if (a !== b) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, a, b);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tck_bit(input logic ms, di, dms, ddi,
                           input logic [1:0] ex);
        exp_q.push_back(ex);
        i_jtag_ctl_model.step(ms, di, dms, ddi);
    endtask

    // tms pattern sent lsb first; output stays off outside shifting
    task automatic walk(input logic [4:0] ms, input int n);
        for (int i = 0; i < n; i++)
            tck_bit(ms[i], 1'($urandom), 1'b1, 1'($urandom), 2'h0);
    endtask

    // from reset: load code, update, then park in shift-dr
    task automatic load_ir(input logic [2:0] c);
        walk(5'h06, 5);
        for (int i = 0; i < 3; i++)
            tck_bit(i == 2, c[i], 1'b1, 1'b1, {1'b1, i == 0});
        chk({test_reset, instr}, 4'h1);
        tck_bit(1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
        // new code lands only as update-ir is left
        chk({test_reset, instr}, 4'h1);
        tck_bit(1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
        chk({test_reset, instr}, {1'b0, c});
        walk(5'h00, 2);
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (got) begin
            if (exp_q.size() == 0)
                chk(4'h1, 4'h0);
            else
                chk({2'h0, got_val}, {2'h0, exp_q.pop_front()});
        end
        if (cyc == 9000) begin
            fails++;
            $display("mismatch at %0t: run did not finish", $time);
            test_done();
        end
    end

    initial begin
        void'($urandom(28));
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        // pins left floating: port must stay quiet in reset
        repeat (40) @(posedge mclk);
        chk({test_reset, instr}, 4'h9);
        chk({2'h0, tdo_oe, tdo}, 4'h0);
        walk(5'h04, 5);
        for (int i = 0; i < 32; i++)
            tck_bit(i == 31, 1'($urandom), 1'b1, 1'b1,
                    {1'b1, ID_VAL[i]});
        walk(5'h0F, 4);
        chk({test_reset, instr}, 4'h9);
        for (int k = 0; k < 3; k++) begin
            code = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'($urandom_range(6, 2));
            load_ir(code);
            prev = 1'b0;
            // floating data input must shift in ones
            for (int j = 0; j < 8; j++) begin
                di = 1'($urandom);
                dd = 1'($urandom);
                tck_bit(1'b0, di, 1'b1, dd, {1'b1, prev});
                prev = di | ~dd;
            end
            // second pass (k == 1) leaves mode select floating, others drive it high
            for (int j = 0; j < 5; j++) begin
                tck_bit(1'b1, 1'b0, k != 1, 1'b1,
                        (j == 0) ? {1'b1, prev} : 2'h0);
                if (j == 3)
                    chk({test_reset, instr}, {1'b0, code});
            end
            chk({test_reset, instr}, 4'h9);
        end
        load_ir(3'h7);
        tck_bit(1'b0, 1'b1, 1'b1, 1'b1, 2'h2);
        rst_b <= 1'b0;
        repeat (5) @(posedge mclk);
        chk({test_reset, instr}, 4'h9);
        chk({2'h0, tdo_oe, tdo}, 4'h0);
        rst_b <= 1'b1;
        repeat (40) @(posedge mclk);
        chk({test_reset, instr}, 4'h9);
        test_done();
    end
endmodule
